/* File: rtl/ucf_pkg.sv */
// constants for the serial transceiver control block
// assumes a 32-bit apb slave with byte addresses in the low 12 bits
package ucf_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_CR1 = 12'h000;
    localparam logic [11:0] ADDR_CR2 = 12'h004;
    localparam logic [11:0] ADDR_SR = 12'h008;
    localparam logic [11:0] ADDR_BRG = 12'h00c;
    localparam logic [11:0] ADDR_DATA = 12'h010;
    // ctrl_reg_one fields
    localparam int CR1_ON = 7;
    localparam int CR1_WL = 6;
    localparam int CR1_PAR = 5;
    localparam int CR1_ODD = 4;
    localparam int CR1_STOP = 3;
    localparam int CR1_BRK = 2;
    localparam int CR1_RX8 = 1;
    localparam int CR1_TX8 = 0;
    // ctrl_reg_two fields
    localparam int CR2_TXON = 7;
    localparam int CR2_RXON = 6;
    localparam int CR2_HS = 5;
    // status fields
    localparam int SR_PERR = 7;
    localparam int SR_NOISE = 6;
    localparam int SR_FERR = 5;
    localparam int SR_OERR = 4;
    localparam int SR_RIDLE = 3;
    localparam int SR_RXAV = 2;
    localparam int SR_TIDLE = 1;
    localparam int SR_TXE = 0;
    // reset values and write masks
    localparam logic [7:0] CR1_RST = 8'h00;
    localparam logic [7:0] CR2_RST = 8'h00;
    localparam logic [7:0] BRG_RST = 8'h00;
    localparam logic [7:0] CR1_WMASK = 8'hfd;
    // clocks per bit = (divisor + 1) * oversample
    localparam logic [7:0] OS_LOW = 8'h10;
    localparam logic [7:0] OS_HIGH = 8'h04;
    // least break length in bit times
    localparam logic [3:0] BRK_BITS = 4'hd;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} ucf_tx_e;
    typedef enum logic {RX_IDLE, RX_SHIFT} ucf_rx_e;
endpackage : ucf_pkg

/* File: rtl/ucf_top.sv */
// serial transceiver with control registers, status and frame engine
// assumes an apb master on pclk and an asynchronous serial partner
// Overview of operation
// RULE1: global enable low disables everything and floats both serial pins
// RULE2: global enable high gives pins to transmitter and receiver enables
// RULE3: global disable empties data buffers and resets baud counters
// RULE4: global disable clears enables, break, data and error flags; sets idles
// RULE5: global disable keeps other control bits and the baud divisor
// RULE6: clearing global enable ends any frame in progress at once
// RULE7: word length select picks 8 or 9 data bits
// RULE8: ninth bit received goes to a read-only bit; sent from a written bit
// RULE9: ninth transmit bit is write-only; ninth receive bit read-only
// RULE10: parity bit generated and checked only while parity is on
// RULE11: parity type one means odd parity, zero means even
// RULE12: stop select zero gives one stop bit, one gives two
// RULE13: break finishes buffered data, then holds line low 13 bits or more
// RULE14: transmitter off aborts sending, resets buffer, floats output
// RULE15: output driven only while transmitter and global enable are high
// RULE16: receiver off aborts reception, resets buffer, releases input
// RULE17: receiver claims input only while receiver and global enable high
// RULE18: enabling the transmitter raises the buffer-empty flag
// RULE19: high speed bit and divisor together set the bit rate
// RULE20: register writes act from the next clock, side effects included
module ucf_top
    import ucf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic serial_out_pin,
    output logic serial_out_pin_oe_n,
    input wire logic serial_in_pin,
    output logic serial_in_claim
);
    // configuration registers
    logic [7:0] cr1_r, cr1_nxt, cr2_r, cr2_nxt, brg_r, brg_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic wr_acc, rd_acc, mapped, gen, tx_run, rx_run, wl, par, odd, stop2;
    logic [15:0] bit_len;
    // transmitter state
    ucf_tx_e tx_st_r, tx_st_nxt;
    logic [8:0] tx_hold_r, tx_hold_nxt;
    logic tx_full_r, tx_full_nxt;
    logic [12:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_left_r, tx_left_nxt, brk_cnt_r, brk_cnt_nxt;
    logic [15:0] tx_cnt_r, tx_cnt_nxt;
    logic tx_idle_flag, tx_buf_empty_flag;
    // receiver state
    ucf_rx_e rx_st_r, rx_st_nxt;
    logic rx_s1_r, rx_s2_r, rx_prev_r;
    logic [12:0] rx_sh_r, rx_sh_nxt;
    logic [3:0] rx_idx_r, rx_idx_nxt, rx_len;
    logic [15:0] rx_cnt_r, rx_cnt_nxt;
    logic [7:0] rx_data_r, rx_data_nxt;
    logic rx_ninth_bit_r, rx_ninth_bit_nxt;
    logic rx_av_r, rx_av_nxt, oerr_r, oerr_nxt, ferr_r, ferr_nxt;
    logic perr_r, perr_nxt, noise_r, noise_nxt, rx_nz_r, rx_nz_nxt;
    logic [3:0] sp;
    logic [7:0] status;

    // frame builder: start bit, data lsb first, parity, stop bits
    function automatic logic [16:0] build_frame(input logic [8:0] d,
            input logic w9, input logic pe, input logic po,
            input logic s2);
        logic [12:0] f;
        logic [3:0] idx;
        f = '1;
        f[0] = 1'b0;
        idx = 4'h1;
        for (int i = 0; i < 9; i++) begin
            if (i < 8 || w9) begin
                f[idx] = d[i];
                idx = idx + 4'h1;
            end
        end
        if (pe) begin
            f[idx] = (^(d & {w9, 8'hff})) ^ po; // RULE10 RULE11
            idx = idx + 4'h1;
        end
        idx = idx + 4'h1 + {3'h0, s2}; // RULE12
        return {idx, f};
    endfunction

    // bus decode; zero wait states, error on unmapped address
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign mapped = (paddr == ADDR_CR1) || (paddr == ADDR_CR2) ||
        (paddr == ADDR_SR) || (paddr == ADDR_BRG) || (paddr == ADDR_DATA);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_r;
    // derived controls
    assign gen = cr1_r[CR1_ON];
    assign tx_run = gen & cr2_r[CR2_TXON]; // RULE2 RULE15
    assign rx_run = gen & cr2_r[CR2_RXON]; // RULE2 RULE17
    assign wl = cr1_r[CR1_WL];
    assign par = cr1_r[CR1_PAR];
    assign odd = cr1_r[CR1_ODD];
    assign stop2 = cr1_r[CR1_STOP];
    // rate needs only a multiply, traded against a finer fractional divider
    assign bit_len = 16'({8'h00, brg_r} + 16'h0001) *
        16'(cr2_r[CR2_HS] ? OS_HIGH : OS_LOW); // RULE19
    // pins: output enable low while driving
    assign serial_out_pin_oe_n = ~tx_run; // RULE1 RULE14 RULE15
    assign serial_out_pin = (tx_st_r == TX_SHIFT) ? tx_sh_r[0] :
        (tx_st_r != TX_BREAK); // RULE13
    assign serial_in_claim = rx_run; // RULE1 RULE16 RULE17
    // status view
    assign tx_buf_empty_flag = ~tx_full_r; // RULE18
    assign tx_idle_flag = (tx_st_r == TX_IDLE) & ~tx_full_r &
        ~(cr1_r[CR1_BRK] & tx_run);
    always_comb begin
        status = 8'h00;
        status[SR_PERR] = perr_r;
        status[SR_NOISE] = noise_r;
        status[SR_FERR] = ferr_r;
        status[SR_OERR] = oerr_r;
        status[SR_RIDLE] = (rx_st_r == RX_IDLE);
        status[SR_RXAV] = rx_av_r;
        status[SR_TIDLE] = tx_idle_flag;
        status[SR_TXE] = tx_buf_empty_flag;
    end

    // control registers written in the access phase; read data captured in the setup phase
    always_comb begin
        cr1_nxt = cr1_r;
        cr2_nxt = cr2_r;
        brg_nxt = brg_r;
        prdata_nxt = prdata_r;
        if (wr_acc && paddr == ADDR_CR1) begin
            cr1_nxt = pwdata[7:0] & CR1_WMASK; // RULE9 RULE20
        end
        if (wr_acc && paddr == ADDR_CR2) begin
            cr2_nxt = pwdata[7:0];
        end
        if (wr_acc && paddr == ADDR_BRG) begin
            brg_nxt = pwdata[7:0];
        end
        // disable clears only these bits; divisor and options stay
        if (!cr1_nxt[CR1_ON]) begin
            cr1_nxt[CR1_BRK] = 1'b0; // RULE4 RULE5
            cr2_nxt[CR2_TXON] = 1'b0; // RULE4
            cr2_nxt[CR2_RXON] = 1'b0; // RULE4
        end
        if (psel && !penable) begin
            unique case (paddr)
                ADDR_CR1: prdata_nxt = {24'h0, cr1_r[7:2],
                    rx_ninth_bit_r, 1'b0}; // RULE8 RULE9
                ADDR_CR2: prdata_nxt = {24'h0, cr2_r};
                ADDR_SR: prdata_nxt = {24'h0, status};
                ADDR_BRG: prdata_nxt = {24'h0, brg_r};
                ADDR_DATA: prdata_nxt = {24'h0, rx_data_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr1_r <= CR1_RST;
            cr2_r <= CR2_RST;
            brg_r <= BRG_RST;
            prdata_r <= 32'h0;
        end else begin
            cr1_r <= cr1_nxt;
            cr2_r <= cr2_nxt;
            brg_r <= brg_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // transmitter: one holding word, a shifter and a break timer
    always_comb begin
        logic [16:0] fr;
        fr = build_frame(tx_hold_r, wl, par, odd, stop2);
        tx_st_nxt = tx_st_r;
        tx_hold_nxt = tx_hold_r;
        tx_full_nxt = tx_full_r;
        tx_sh_nxt = tx_sh_r;
        tx_left_nxt = tx_left_r;
        brk_cnt_nxt = brk_cnt_r;
        tx_cnt_nxt = (tx_cnt_r == 16'h0) ? bit_len - 16'h1 :
            tx_cnt_r - 16'h1;
        // a write while the holding word is full is dropped
        if (wr_acc && paddr == ADDR_DATA && !tx_full_r) begin
            tx_hold_nxt = {cr1_r[CR1_TX8], pwdata[7:0]}; // RULE8
            tx_full_nxt = 1'b1;
        end
        unique case (tx_st_r)
            TX_IDLE: begin
                tx_cnt_nxt = bit_len - 16'h1;
                if (tx_full_r) begin
                    tx_sh_nxt = fr[12:0]; // RULE7
                    tx_left_nxt = fr[16:13];
                    tx_full_nxt = 1'b0; // a write this cycle was dropped
                    tx_st_nxt = TX_SHIFT;
                end else if (cr1_r[CR1_BRK]) begin
                    brk_cnt_nxt = 4'h0; // RULE13
                    tx_st_nxt = TX_BREAK;
                end
            end
            TX_SHIFT: begin
                if (tx_cnt_r == 16'h0) begin
                    tx_sh_nxt = {1'b1, tx_sh_r[12:1]};
                    tx_left_nxt = tx_left_r - 4'h1;
                    if (tx_left_r == 4'h1) begin
                        tx_st_nxt = TX_IDLE;
                    end
                end
            end
            TX_BREAK: begin
                if (tx_cnt_r == 16'h0 && brk_cnt_r != BRK_BITS) begin
                    brk_cnt_nxt = brk_cnt_r + 4'h1;
                end
                // low until both the least length and the clear
                if (brk_cnt_r == BRK_BITS && !cr1_r[CR1_BRK]) begin
                    tx_st_nxt = TX_IDLE; // RULE13
                end
            end
            default: tx_st_nxt = TX_IDLE;
        endcase
        if (!tx_run) begin
            tx_st_nxt = TX_IDLE; // RULE6 RULE14
            tx_full_nxt = 1'b0; // RULE3 RULE4 RULE18
            tx_cnt_nxt = 16'h0; // RULE3
            brk_cnt_nxt = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_r <= TX_IDLE;
            tx_hold_r <= 9'h0;
            tx_full_r <= 1'b0;
            tx_sh_r <= '1;
            tx_left_r <= 4'h0;
            brk_cnt_r <= 4'h0;
            tx_cnt_r <= 16'h0;
        end else begin
            tx_st_r <= tx_st_nxt;
            tx_hold_r <= tx_hold_nxt;
            tx_full_r <= tx_full_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_left_r <= tx_left_nxt;
            brk_cnt_r <= brk_cnt_nxt;
            tx_cnt_r <= tx_cnt_nxt;
        end
    end
    // receive pin synchroniser; the second stage is sampled, and a third stage copy is compared with it for noise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s1_r <= serial_in_pin;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
        end
    end

    // receiver: sample mid-bit, check parity and stop bits
    assign rx_len = 4'(build_frame(9'h0, wl, par, odd, stop2) >> 13);
    assign sp = 4'h9 + {3'h0, wl} + {3'h0, par};
    always_comb begin
        logic rd_data, perr_ev, ferr_ev;
        rd_data = rd_acc && paddr == ADDR_DATA;
        perr_ev = 1'b0;
        ferr_ev = 1'b0;
        rx_st_nxt = rx_st_r;
        rx_sh_nxt = rx_sh_r;
        rx_idx_nxt = rx_idx_r;
        rx_data_nxt = rx_data_r;
        rx_ninth_bit_nxt = rx_ninth_bit_r;
        rx_nz_nxt = rx_nz_r;
        rx_cnt_nxt = (rx_cnt_r == 16'h0) ? bit_len - 16'h1 :
            rx_cnt_r - 16'h1;
        // a data read clears these; a set in that cycle wins below
        rx_av_nxt = rx_av_r & ~rd_data;
        oerr_nxt = oerr_r & ~rd_data;
        ferr_nxt = ferr_r & ~rd_data;
        perr_nxt = perr_r & ~rd_data;
        noise_nxt = noise_r & ~rd_data;
        unique case (rx_st_r)
            RX_IDLE: begin
                rx_cnt_nxt = {1'b0, bit_len[15:1]};
                rx_idx_nxt = 4'h0;
                rx_nz_nxt = 1'b0;
                if (!rx_s2_r) begin
                    rx_st_nxt = RX_SHIFT;
                end
            end
            RX_SHIFT: begin
                if (rx_cnt_r == 16'h0) begin
                    rx_sh_nxt[rx_idx_r] = rx_s2_r;
                    rx_nz_nxt = rx_nz_r | (rx_s2_r != rx_prev_r);
                    rx_idx_nxt = rx_idx_r + 4'h1;
                    if (rx_idx_r == 4'h0 && rx_s2_r) begin
                        rx_st_nxt = RX_IDLE; // false start
                    end else if (rx_idx_r == rx_len - 4'h1) begin
                        rx_st_nxt = RX_IDLE;
                        ferr_ev = ~rx_sh_nxt[sp] |
                            (stop2 & ~rx_sh_nxt[sp + 4'h1]); // RULE12
                        perr_ev = par & (^(rx_sh_nxt[9:1] & {wl, 8'hff}) ^
                            odd ^ rx_sh_nxt[sp - 4'h1]); // RULE10 RULE11
                        if (rx_av_r && !rd_data) begin
                            oerr_nxt = 1'b1;
                        end else begin
                            rx_data_nxt = rx_sh_nxt[8:1];
                            if (wl) begin
                                rx_ninth_bit_nxt = rx_sh_nxt[9]; // RULE8
                            end
                            rx_av_nxt = 1'b1;
                            ferr_nxt = ferr_ev;
                            perr_nxt = perr_ev;
                            noise_nxt = rx_nz_nxt;
                        end
                    end
                end
            end
        endcase
        if (!rx_run) begin
            rx_st_nxt = RX_IDLE; // RULE6 RULE16
            rx_cnt_nxt = 16'h0; // RULE3
            rx_av_nxt = 1'b0; // RULE3 RULE4
            oerr_nxt = 1'b0; // RULE4
            ferr_nxt = 1'b0;
            perr_nxt = 1'b0;
            noise_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_r <= RX_IDLE;
            rx_sh_r <= 13'h0;
            rx_idx_r <= 4'h0;
            rx_cnt_r <= 16'h0;
            rx_data_r <= 8'h00;
            rx_ninth_bit_r <= 1'b0;
            rx_av_r <= 1'b0;
            oerr_r <= 1'b0;
            ferr_r <= 1'b0;
            perr_r <= 1'b0;
            noise_r <= 1'b0;
            rx_nz_r <= 1'b0;
        end else begin
            rx_st_r <= rx_st_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_idx_r <= rx_idx_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_data_r <= rx_data_nxt;
            rx_ninth_bit_r <= rx_ninth_bit_nxt;
            rx_av_r <= rx_av_nxt;
            oerr_r <= oerr_nxt;
            ferr_r <= ferr_nxt;
            perr_r <= perr_nxt;
            noise_r <= noise_nxt;
            rx_nz_r <= rx_nz_nxt;
        end
    end
endmodule // ucf_top

/* File: verif/ucf_props.sv */
// checker for the serial control block, bound to ucf_top
// assumes one pclk domain; shadows the control bits from apb writes
module ucf_props
    import ucf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_out_pin,
    input wire logic serial_out_pin_oe_n,
    input wire logic serial_in_pin,
    input wire logic serial_in_claim
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc, wr1, wr2;
    logic [7:0] cr1_r, cr2_r;
    logic off_r, txe_r;
    assign acc = psel && penable && pready;
    assign wr1 = acc && pwrite && paddr == ADDR_CR1;
    assign wr2 = acc && pwrite && paddr == ADDR_CR2;
    // shadow of control bits; off_r and txe_r mark a fresh disable or enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr1_r <= 8'h00;
            cr2_r <= 8'h00;
            off_r <= 1'b0;
            txe_r <= 1'b0;
        end else begin
            if (wr1)
                cr1_r <= pwdata[7:0] & (pwdata[7] ? 8'hff : 8'hfb);
            if (wr2)
                cr2_r <= pwdata[7:0];
            else if (wr1 && !pwdata[7])
                cr2_r <= cr2_r & 8'h3f;
            if (acc && pwrite)
                off_r <= wr1 && !pwdata[7];
            // only a rising tx enable promises an empty buffer
            if (acc && pwrite)
                txe_r <= wr2 && pwdata[7] && !cr2_r[7] && cr1_r[7] && !cr1_r[2];
        end
    end
    sequence off_wr_s;
        wr1 && !pwdata[7];
    endsequence
    sequence sr_rd_s;
        acc && !pwrite && paddr == ADDR_SR;
    endsequence
    out_float_a: assert property (
        serial_out_pin_oe_n == !(cr1_r[7] && cr2_r[7]))
        else $error("transmit pin enable disagrees with control bits");
    in_claim_a: assert property (
        serial_in_claim == (cr1_r[7] && cr2_r[6]))
        else $error("receive claim disagrees with control bits");
    off_float_a: assert property (
        off_wr_s |=> (serial_out_pin_oe_n && !serial_in_claim) [*2])
        else $error("pins not released after global disable");
    off_status_a: assert property (
        sr_rd_s ##0 off_r |-> prdata[7:0] == 8'h0b)
        else $error("status after global disable wrong");
    cr1_keep_a: assert property (
        acc && !pwrite && paddr == ADDR_CR1
        |-> (prdata[7:0] & 8'hfd) == {cr1_r[7:2], 2'b00})
        else $error("first control register readback wrong");
    cr2_keep_a: assert property (
        acc && !pwrite && paddr == ADDR_CR2 |-> prdata[7:0] == cr2_r)
        else $error("second control register readback wrong");
    tx_empty_a: assert property (
        sr_rd_s ##0 txe_r |-> prdata[SR_TXE] && prdata[SR_TIDLE])
        else $error("buffer empty not raised by tx enable");
    line_idle_a: assert property (
        txe_r |-> serial_out_pin)
        else $error("serial output not idle high");
endmodule // ucf_props

/* File: verif/ucf_remote.sv */
// remote serial transceiver model on the block's serial pins
// assumes the bench sets frame format before traffic; idle line is high
module ucf_remote (
    input wire logic pclk,
    input wire logic [7:0] bit_clks,
    input wire logic nine,
    input wire logic par_on,
    input wire logic odd,
    input wire logic two_stop,
    input wire logic line,
    input wire logic line_oe_n,
    input wire logic send,
    input wire logic bad_par,
    input wire logic [8:0] send_word,
    output logic rx_line,
    output logic busy,
    output logic got_stb,
    output logic [10:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    int rk = -2;
    int rc, nb, nt;
    int tk = -1;
    int tc, tn;
    logic [15:0] sm, fr;
    logic [8:0] w;
    assign busy = (tk >= 0);
    // receiver: mid-bit samples, frame dropped when the line is released
    always @(posedge pclk) begin
        nb = nine ? 9 : 8;
        nt = 2 + nb + par_on + two_stop;
        got_stb <= 1'b0;
        if (line_oe_n)
            rk = -2;
        else if (rk == -2) begin
            if (line)
                rk = -1;
        end else if (rk == -1) begin
            if (!line) begin
                rk = 0;
                rc = bit_clks / 2;
            end
        end else if (rc > 0)
            rc = rc - 1;
        else begin
            sm[rk] = line;
            rc = bit_clks - 1;
            rk = rk + 1;
            if (rk == nt) begin
                w = nine ? sm[9:1] : {1'b0, sm[8:1]};
                got <= {!sm[0] && sm[nt-1] && (sm[nt-2] || !two_stop),
                        par_on && sm[nb+1], w};
                got_stb <= 1'b1;
                rk = -2;
            end
        end
    end
    // transmitter: start, data lsb first, parity, stop bits all ones
    always @(posedge pclk) begin
        if (send) begin
            w = nine ? send_word : {1'b0, send_word[7:0]};
            fr = 16'hfffe;
            for (int i = 0; i < nb; i++)
                fr[1+i] = w[i];
            if (par_on)
                fr[nb+1] = ^w ^ odd ^ bad_par;
            tn = 2 + nb + par_on + two_stop;
            tk = 0;
            tc = 0;
        end
        if (tk >= 0) begin
            rx_line <= fr[tk];
            tc = tc + 1;
            if (tc == bit_clks) begin
                tc = 0;
                tk = (tk + 1 == tn) ? -1 : tk + 1;
            end
        end else
            rx_line <= 1'b1;
    end
endmodule // ucf_remote

/* File: verif/uart_control_frame_config_tb.sv */
// self-checking bench for the serial control block and a remote model
// assumes divisor 1 in high speed mode, so one bit is 8 clocks
module uart_control_frame_config_tb
    import ucf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, serial_out_pin, serial_out_pin_oe_n;
    logic serial_in_pin, serial_in_claim, busy, got_stb, t8;
    logic nine = 1'b0;
    logic par_on = 1'b0;
    logic odd = 1'b0;
    logic two_stop = 1'b0;
    logic send = 1'b0;
    logic bad_par = 1'b0;
    logic [8:0] send_word = 9'h000;
    logic [8:0] rw, w;
    logic [10:0] got;
    logic [15:0] nr;
    logic [15:0] exp_rd[$];
    logic [10:0] exp_tx[$];
    int n_fail = 0;
    int checks_done = 0;
    int run;
    always #20 pclk = ~pclk;
    ucf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_out_pin(serial_out_pin),
        .serial_out_pin_oe_n(serial_out_pin_oe_n),
        .serial_in_pin(serial_in_pin), .serial_in_claim(serial_in_claim));
    ucf_remote u_remote (.pclk(pclk), .bit_clks(8'h08), .nine(nine),
        .par_on(par_on), .odd(odd), .two_stop(two_stop),
        .line(serial_out_pin), .line_oe_n(serial_out_pin_oe_n),
        .send(send), .bad_par(bad_par), .send_word(send_word),
        .rx_line(serial_in_pin), .busy(busy), .got_stb(got_stb), .got(got));
    task automatic chk_rd(input logic [7:0] e, input logic [7:0] m,
                          input logic [7:0] g);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            n_fail++;
            $display("ERROR %0t exp %h got %h", $time, e & m, g & m);
        end
    endtask
    task automatic chk_tx(input logic [10:0] e, input logic [10:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask
    // one apb transfer, released a cycle before the next may start
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        exp_rd.push_back({m, e});
        xfer(1'b0, a, 8'h00);
    endtask
    // waits for both line directions to go quiet, then two bit times more
    task automatic settle();
        int i = 0;
        while ((busy || exp_tx.size() > 0) && i < 3000) begin
            @(posedge pclk);
            i++;
        end
        repeat (16) @(posedge pclk);
    endtask
    task automatic complete_run();
        n_fail += exp_tx.size() + exp_rd.size(); // notes never answered
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // oldest note is compared when a read completes or a frame arrives
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_rd.size() > 0) begin
            nr = exp_rd.pop_front();
            chk_rd(nr[7:0], nr[15:8], prdata[7:0]);
        end
        if (got_stb === 1'b1 && exp_tx.size() > 0)
            chk_tx(exp_tx.pop_front(), got);
        // bus error only on the one unmapped address used
        if (psel && penable && pready)
            chk_rd({7'h0, paddr == 12'h020}, 8'h01, {7'h0, pslverr});
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        complete_run();
    end
    initial begin
        void'($urandom(10910));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CR1, 8'h00, 8'hfd);
        rd(ADDR_CR2, 8'h00, 8'hff);
        rd(12'h020, 8'h00, 8'hff);
        xfer(1'b1, ADDR_BRG, 8'h01);
        xfer(1'b1, ADDR_CR1, 8'h80);
        xfer(1'b1, ADDR_CR2, 8'he0);
        rd(ADDR_SR, 8'h0b, 8'h0b);
        // every word length, parity and stop combination, both directions
        for (int m = 0; m < 16; m++) begin
            t8 = 1'($urandom);
            rw = 9'($urandom);
            {nine, par_on, odd, two_stop} <= 4'(m);
            bad_par <= m[2] & m[0];
            xfer(1'b1, ADDR_CR1, {1'b1, 4'(m), 2'b00, t8});
            send_word <= rw;
            send <= 1'b1;
            @(posedge pclk);
            send <= 1'b0;
            for (int k = 0; k < 2; k++) begin
                w = {m[3] & t8, 8'($urandom)};
                exp_tx.push_back({1'b1, m[2] & (^w ^ m[1]), w});
                xfer(1'b1, ADDR_DATA, w[7:0]);
            end
            settle();
            rd(ADDR_SR, {m[2] & m[0], 7'h0f}, 8'hff);
            rd(ADDR_CR1, {1'b1, 4'(m), 1'b0, rw[8], 1'b0},
               m[3] ? 8'hff : 8'hfd);
            rd(ADDR_DATA, rw[7:0], 8'hff);
        end
        // break waits for the queued word, then holds the line low
        {nine, par_on, odd, two_stop} <= 4'h0;
        xfer(1'b1, ADDR_CR1, 8'h80);
        exp_tx.push_back({2'b10, 9'h0ff});
        exp_tx.push_back(11'h000);
        xfer(1'b1, ADDR_DATA, 8'hff);
        xfer(1'b1, ADDR_CR1, 8'h84);
        run = 0;
        repeat (300) begin
            @(posedge pclk);
            run = (serial_out_pin === 1'b0) ? run + 1 : 0;
        end
        chk_rd(8'h01, 8'h01, {7'h0, run >= 13 * 8});
        xfer(1'b1, ADDR_CR1, 8'h80);
        repeat (16) @(posedge pclk);
        chk_rd(8'h01, 8'h01, {7'h0, serial_out_pin});
        // tx off mid frame, then global off mid frame
        xfer(1'b1, ADDR_DATA, 8'h00);
        repeat (20) @(posedge pclk);
        xfer(1'b1, ADDR_CR2, 8'h60);
        rd(ADDR_SR, 8'h03, 8'h03);
        xfer(1'b1, ADDR_CR2, 8'he0);
        xfer(1'b1, ADDR_DATA, 8'h00);
        repeat (20) @(posedge pclk);
        xfer(1'b1, ADDR_CR1, 8'h5c);
        rd(ADDR_SR, 8'h0b, 8'hff);
        rd(ADDR_CR1, 8'h58, 8'hfd);
        rd(ADDR_CR2, 8'h20, 8'hff);
        rd(ADDR_BRG, 8'h01, 8'hff);
        complete_run();
    end
endmodule // uart_control_frame_config_tb
bind ucf_top ucf_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_out_pin(serial_out_pin),
    .serial_out_pin_oe_n(serial_out_pin_oe_n),
    .serial_in_pin(serial_in_pin), .serial_in_claim(serial_in_claim));
